// ---- crc_bc4_checker.sv ----
// What this block does
// - On a x4 part in burst-chop-four mode only 16 data bits feed the tree and the rest are 1.
// - With the start column bit low on x4, lane n feeds tree bits 8n..8n+3 from beats 0-3, CRC sits in beats 8 and 9.
// - With the start column bit high on x4, lane n feeds tree bits 8n+4..8n+7, CRC placement unchanged.
// - A high start column bit moves the beats to each byte's upper nibble and pads the lower nibble with 1.
// - On x8 the tree takes 36 real bits, eight data lanes plus the mask lane over four beats.
// - On x8 with the start column bit low, tree bits 64-67 come from the mask lane if masking or inversion is on, else 1.
// - On x8 with the start column bit high, tree bits 68-71 come from the mask lane if enabled, else 1.
// - On x8 lanes 0-7 carry CRC bits 0-7 in beat 8, while beat 9 and the mask lane in beats 8-9 are 1.
// - A x16 part has two identical independent trees, one per byte half, each with 36 real inputs.
// - On x16 with the start column bit low, bits 64-67 and 136-139 come from the lower and upper mask lanes if enabled.
// - On x16 lanes 8-15 carry CRC bits 8-15 in beat 8; beat 9 and both mask lanes there are 1.
// - On x16 with the start column bit high the upper mask lane feeds bits 140-143 and upper lanes feed upper nibbles.
// - The start column bit picks which four-beat half is the critical data; on-the-fly chop is not used.
// - Each tree computes an 8-bit CRC over 72 inputs with polynomial terms 0,1,2,8 from a zero start.

`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO between the crossing stage and the checker
module crc_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // Extra pointer bit tells full from empty
  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  // Storage needs no reset
  always_ff @(posedge core_clk_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

  // Pointers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : crc_word_fifo

module crc_bc4_checker
  import crc_bc4_pkg::*;
#(
  parameter int FIFO_W = WORD_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                link_clk_i,
  input  wire logic                burst_start_i,
  input  wire logic                start_column_bit_i,
  input  wire logic [DQ_LANES-1:0] beat_dq_i,
  input  wire logic                lower_mask_inversion_lane_i,
  input  wire logic                upper_mask_inversion_lane_i,
  input  wire logic [1:0]          organisation_i,
  input  wire logic                mask_enable_i,
  input  wire logic                check_hold_i,
  output logic                     check_done_o,
  output logic                     crc_error_o,
  output logic [CRC_W-1:0]         crc_tree0_o,
  output logic [CRC_W-1:0]         crc_tree1_o,
  output logic                     burst_dropped_o
);

  // ---------------- Link domain ----------------
  logic                 link_rst_s1;
  logic                 link_rst_n;
  link_state_type       link_state;
  logic [3:0]           beat_cnt;
  logic                 scb_q;
  logic [BEAT_W-1:0]    data_q [DATA_BEATS];
  logic [BEAT_W-1:0]    crc_a_q;
  logic [WORD_W-1:0]    link_word;
  logic                 req_tgl;
  logic                 drop_tgl;
  logic                 ack_s1;
  logic                 ack_s2;
  logic                 ack_tgl;

  wire [BEAT_W-1:0] beat_now = {upper_mask_inversion_lane_i, lower_mask_inversion_lane_i, beat_dq_i};
  wire              link_busy = (req_tgl != ack_s2);

  // Reset released in step with the link clock
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_rst_s1 <= 1'b0;
      link_rst_n  <= 1'b0;
    end else begin
      link_rst_s1 <= 1'b1;
      link_rst_n  <= link_rst_s1;
    end
  end

  // Acknowledge from core back to link
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Beat capture; beats 4-7 carry no tree data so they are skipped
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_state <= LS_IDLE;
      beat_cnt   <= 4'h0;
      scb_q      <= 1'b0;
      crc_a_q    <= '0;
      for (int i = 0; i < DATA_BEATS; i++) data_q[i] <= '0;
    end else begin
      case (link_state)
        LS_IDLE: begin
          if (burst_start_i) begin
            scb_q      <= start_column_bit_i;
            data_q[0]  <= beat_now;
            beat_cnt   <= 4'h1;
            link_state <= LS_DATA;
          end
        end
        LS_DATA: begin
          data_q[beat_cnt[1:0]] <= beat_now;
          beat_cnt <= beat_cnt + 4'h1;
          if (beat_cnt == LAST_DATA) link_state <= LS_PAD;
        end
        LS_PAD: begin
          beat_cnt <= beat_cnt + 4'h1;
          if (beat_cnt == LAST_PAD) link_state <= LS_CRC;
        end
        LS_CRC: begin
          beat_cnt <= beat_cnt + 4'h1;
          if (beat_cnt == CRC_BEAT_A) crc_a_q <= beat_now;
          else link_state <= LS_IDLE;
        end
        default: link_state <= LS_IDLE;
      endcase
    end
  end

  // Hand the burst over; held stable until acknowledged, dropped if still busy
  wire burst_end = (link_state == LS_CRC) && (beat_cnt != CRC_BEAT_A);
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_word <= '0;
      req_tgl   <= 1'b0;
      drop_tgl  <= 1'b0;
    end else if (burst_end && !link_busy) begin
      link_word <= {beat_now, crc_a_q, data_q[3], data_q[2], data_q[1], data_q[0], scb_q};
      req_tgl   <= ~req_tgl;
    end else if (burst_end) begin
      drop_tgl  <= ~drop_tgl;
    end
  end

  // ---------------- Core domain ----------------
  logic              req_s1;
  logic              req_s2;
  logic              req_s3;
  logic              drop_s1;
  logic              drop_s2;
  logic              drop_s3;
  logic              stage_valid;
  logic [WORD_W-1:0] stage_word;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out;

  // Edges are found by comparing the second and third stages of each synchroniser
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {req_s1, req_s2, req_s3}    <= 3'h0;
      {drop_s1, drop_s2, drop_s3} <= 3'h0;
    end else begin
      {req_s1, req_s2, req_s3}    <= {req_tgl, req_s1, req_s2};
      {drop_s1, drop_s2, drop_s3} <= {drop_tgl, drop_s1, drop_s2};
    end
  end

  wire new_req    = req_s2 ^ req_s3;
  wire stage_push = stage_valid && fifo_in_ready;

  // Staging register; a full FIFO stalls it, which stalls the acknowledge
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_valid <= 1'b0;
      stage_word  <= '0;
      ack_tgl     <= 1'b0;
    end else if (new_req) begin
      stage_valid <= 1'b1;
      stage_word  <= link_word;
    end else if (stage_push) begin
      stage_valid <= 1'b0;
      ack_tgl     <= req_s3;
    end
  end

  crc_word_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (stage_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (stage_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!check_hold_i),
    .out_data_o  (fifo_out)
  );

  // Unpack the word at the FIFO head
  wire                out_scb = fifo_out[0];
  wire [BEAT_W-1:0]   out_beat [DATA_BEATS];
  wire [BEAT_W-1:0]   crc_beat_a = fifo_out[1 + DATA_BEATS*BEAT_W +: BEAT_W];
  wire [BEAT_W-1:0]   crc_beat_b = fifo_out[1 + (DATA_BEATS+1)*BEAT_W +: BEAT_W];
  wire org_type       org = org_type'(organisation_i);
  wire                pop = fifo_out_valid && !check_hold_i;
  wire [TREE_IN_W-1:0] tree_in [TREES];

  // Tree input mapping: unused positions padded with 1
  for (genvar b = 0; b < DATA_BEATS; b++) begin : g_unpack
    assign out_beat[b] = fifo_out[1 + b*BEAT_W +: BEAT_W];
  end
  for (genvar t = 0; t < TREES; t++) begin : g_tree
    wire mask_real = mask_enable_i && ((org == ORG_X16) || (t == 0 && org == ORG_X8));
    for (genvar n = 0; n < TREE_LANES; n++) begin : g_lane
      wire lane_real = (org == ORG_X16 && t == 1) ||
                       (t == 0 && (org == ORG_X16 || org == ORG_X8 || (n < X4_LANES && org == ORG_X4)));
      for (genvar b = 0; b < DATA_BEATS; b++) begin : g_beat
        assign tree_in[t][n*LANE_STRIDE + b] = (lane_real && !out_scb) ?
                                               out_beat[b][t*TREE_LANES + n] : 1'b1;
        assign tree_in[t][n*LANE_STRIDE + HALF_OFS + b] = (lane_real && out_scb) ?
                                               out_beat[b][t*TREE_LANES + n] : 1'b1;
      end
    end
    for (genvar b = 0; b < DATA_BEATS; b++) begin : g_mask
      assign tree_in[t][MASK_BASE + b] = (mask_real && !out_scb) ?
                                         out_beat[b][LMASK_LANE + t] : 1'b1;
      assign tree_in[t][MASK_BASE + HALF_OFS + b] = (mask_real && out_scb) ?
                                         out_beat[b][LMASK_LANE + t] : 1'b1;
    end
  end

  // Serial form of the tree, first serial bit is the top input
  function automatic logic [CRC_W-1:0] crc_calc(input logic [TREE_IN_W-1:0] d);
    logic [CRC_W-1:0] c;
    logic             fb;
    c = CRC_INIT;
    for (int i = TREE_IN_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ d[i];
      c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc_calc

  // Received CRC: x4 spreads it over beats 8 and 9, wider parts use beat 8 only
  wire [CRC_W-1:0] calc0 = crc_calc(tree_in[0]);
  wire [CRC_W-1:0] calc1 = crc_calc(tree_in[1]);
  wire [CRC_W-1:0] rx0   = (org == ORG_X4) ? {crc_beat_b[3:0], crc_beat_a[3:0]}
                                           : crc_beat_a[7:0];
  wire [CRC_W-1:0] rx1   = crc_beat_a[15:8];
  wire mismatch = (calc0 != rx0) || ((org == ORG_X16) && (calc1 != rx1));

  // Result registers; done and error are one-cycle pulses per checked burst, tree values are held
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      check_done_o    <= 1'b0;
      crc_error_o     <= 1'b0;
      crc_tree0_o     <= CRC_INIT;
      crc_tree1_o     <= CRC_INIT;
      burst_dropped_o <= 1'b0;
    end else begin
      check_done_o    <= pop;
      crc_error_o     <= pop && mismatch;
      burst_dropped_o <= drop_s2 ^ drop_s3;
      if (pop) begin
        crc_tree0_o <= calc0;
        crc_tree1_o <= calc1;
      end
    end
  end

  // ---------------- Checks ----------------
  property p_x4_pad;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (org == ORG_X4) |-> (tree_in[0][71:32] == 40'hff_ffff_ffff) && (tree_in[1] == '1);
  endproperty
  a_x4_pad: assert property (p_x4_pad) else $error("x4 padding wrong");

  property p_x4_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (org == ORG_X4 && !out_scb) |-> (tree_in[0][7:4] == 4'hf) &&
      (tree_in[0][27:24] == {out_beat[3][3], out_beat[2][3], out_beat[1][3], out_beat[0][3]});
  endproperty
  a_x4_low: assert property (p_x4_low) else $error("x4 low half map wrong");

  property p_high_half;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (org != ORG_X4 && out_scb) |-> (tree_in[0][3:0] == 4'hf) &&
      (tree_in[0][7:4] == {out_beat[3][0], out_beat[2][0], out_beat[1][0], out_beat[0][0]});
  endproperty
  a_high_half: assert property (p_high_half) else $error("upper nibble map wrong");

  property p_x8_mask;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (org == ORG_X8 && mask_enable_i && !out_scb) |-> (tree_in[0][71:68] == 4'hf) &&
      (tree_in[0][67:64] == {out_beat[3][16], out_beat[2][16], out_beat[1][16], out_beat[0][16]});
  endproperty
  a_x8_mask: assert property (p_x8_mask) else $error("x8 mask lane map wrong");

  property p_mask_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !mask_enable_i |-> (tree_in[0][71:64] == 8'hff) && (tree_in[1][71:64] == 8'hff);
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("mask inputs not padded");

  property p_x16_upper_mask;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (org == ORG_X16 && mask_enable_i && out_scb) |-> (tree_in[1][67:64] == 4'hf) &&
      (tree_in[1][71:68] == {out_beat[3][17], out_beat[2][17], out_beat[1][17], out_beat[0][17]});
  endproperty
  a_x16_upper_mask: assert property (p_x16_upper_mask) else $error("upper mask lane wrong");

  property p_upper_tree_error;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (pop && org == ORG_X16 && calc1 != crc_beat_a[15:8]) |=> crc_error_o && check_done_o;
  endproperty
  a_upper_tree_error: assert property (p_upper_tree_error) else $error("upper tree miss");

  property p_clean_burst;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (pop && org == ORG_X8 && calc0 == crc_beat_a[7:0]) |=> check_done_o && !crc_error_o
      && (crc_tree0_o == $past(crc_beat_a[7:0]));
  endproperty
  a_clean_burst: assert property (p_clean_burst) else $error("false crc error");

  property p_burst_len;
    @(posedge link_clk_i) disable iff (!link_rst_n)
    (link_state == LS_IDLE && burst_start_i) |=>
      (link_state != LS_IDLE)[*8] ##1 (link_state == LS_CRC) ##1 (link_state == LS_IDLE);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

  // Only a zero start keeps the tree linear across the two halves
  property p_zero_tree;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (pop && org == ORG_X16) |-> ((calc0 ^ calc1) == crc_calc(tree_in[0] ^ tree_in[1]));
  endproperty
  a_zero_tree: assert property (p_zero_tree) else $error("zero start violated");

  c_error:   cover property (@(posedge core_clk_i) disable iff (!nrst_i) crc_error_o);
  c_x16_ok:  cover property (@(posedge core_clk_i) disable iff (!nrst_i)
                             pop && org == ORG_X16 && !mismatch);
  c_full:    cover property (@(posedge core_clk_i) disable iff (!nrst_i) !fifo_in_ready);
  c_dropped: cover property (@(posedge core_clk_i) disable iff (!nrst_i) burst_dropped_o);

endmodule : crc_bc4_checker

`default_nettype wire

// ---- crc_bc4_pkg.sv ----
package crc_bc4_pkg;

  // Device organisation codes
  typedef enum logic [1:0] {
    ORG_X4  = 2'b00,
    ORG_X8  = 2'b01,
    ORG_X16 = 2'b10
  } org_type;

  // Link capture states
  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_DATA = 2'b01,
    LS_PAD  = 2'b10,
    LS_CRC  = 2'b11
  } link_state_type;

  // Lane layout of one received beat
  localparam int DQ_LANES    = 16;
  localparam int BEAT_W      = 18;
  localparam int LMASK_LANE  = 16;
  localparam int X4_LANES    = 4;
  localparam int TREE_LANES  = 8;
  localparam int TREES       = 2;

  // Burst shape
  localparam int        DATA_BEATS  = 4;
  localparam logic [3:0] LAST_DATA  = 4'h3;
  localparam logic [3:0] LAST_PAD   = 4'h7;
  localparam logic [3:0] CRC_BEAT_A = 4'h8;

  // Tree input layout
  localparam int LANE_STRIDE = 8;
  localparam int HALF_OFS    = 4;
  localparam int MASK_BASE   = 64;
  localparam int TREE_IN_W   = 72;

  // CRC: x^8 + x^2 + x + 1, zero start
  localparam int         CRC_W    = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Word passed from link to core: scb, four data beats, two crc beats
  localparam int WORD_W     = 1 + (DATA_BEATS + 2) * BEAT_W;
  localparam int FIFO_DEPTH = 16;

endpackage : crc_bc4_pkg

// ---- crc_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Controller side of the write link: sends burst-chop-four bursts with CRC beats
module crc_ctrl_model
  import crc_bc4_pkg::*;
(
  output logic                link_clk_o,
  output logic                burst_start_o,
  output logic                start_column_bit_o,
  output logic [DQ_LANES-1:0] beat_dq_o,
  output logic                lower_mask_o,
  output logic                upper_mask_o
);
  // Idle lines at time zero
  initial begin
    link_clk_o         = 1'b0;
    burst_start_o      = 1'b0;
    start_column_bit_o = 1'b0;
    beat_dq_o          = 16'h0000;
    lower_mask_o       = 1'b0;
    upper_mask_o       = 1'b0;
  end

  // Released lines flip so a stale value can never pass for data
  task automatic release_lines();
    burst_start_o      = 1'b0;
    start_column_bit_o = ~start_column_bit_o;
    beat_dq_o          = ~beat_dq_o;
    lower_mask_o       = ~lower_mask_o;
    upper_mask_o       = ~upper_mask_o;
  endtask : release_lines

  // One 12 ns strobe period; data moves 2 ns after the falling edge
  task automatic edge_out(input logic last);
    #5 link_clk_o = 1'b1;
    #5 link_clk_o = 1'b0;
    if (last) release_lines();
    #2;
  endtask : edge_out

  // Free strobe edges, for reset, link start-up, lead edges before a burst and settling after the stall
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) edge_out(1'b0);
  endtask : idle

  // Whole ten-beat burst; lead edges give the capture side time to settle
  task automatic send(input logic [1:0] org, input logic scb,
                      input logic [3:0][DQ_LANES-1:0] dq, input logic [3:0] lm,
                      input logic [3:0] um, input logic [15:0] crc, input int lead);
    idle(lead);
    for (int b = 0; b < 10; b++) begin
      burst_start_o      = (b == 0);
      start_column_bit_o = scb;
      beat_dq_o          = 16'hffff;
      lower_mask_o       = 1'b1;
      upper_mask_o       = 1'b1;
      if (b < 4) begin
        beat_dq_o    = dq[b];
        lower_mask_o = lm[b];
        upper_mask_o = um[b];
      end else if (b == 8) begin
        beat_dq_o = (org == ORG_X4) ? {12'hfff, crc[3:0]} : crc;
      end else if (b == 9 && org == ORG_X4) begin
        beat_dq_o = {12'hfff, crc[7:4]};
      end
      edge_out(b == 9);
    end
  endtask : send
endmodule : crc_ctrl_model

`default_nettype wire

// ---- write_crc_bc4_input_mapping_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fails++; $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module write_crc_bc4_input_mapping_tb_top;
  import crc_bc4_pkg::*;

  typedef struct {
    logic [1:0] org;
    logic [7:0] t0;
    logic [7:0] t1;
    logic       err;
  } note_type;

  logic       core_clk_i, nrst_i, link_clk, bstart, scb, lm, um;
  logic       hold, mask_en, done, err, dropped;
  logic [1:0] org;
  logic [15:0] dq;
  logic [7:0] t0, t1;
  note_type   notes[$];
  int         fails, comparisons, cycles, drops, checks, c0;

  crc_ctrl_model u_model (
    .link_clk_o(link_clk), .burst_start_o(bstart), .start_column_bit_o(scb),
    .beat_dq_o(dq), .lower_mask_o(lm), .upper_mask_o(um));

  crc_bc4_checker DUT (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk),
    .burst_start_i(bstart), .start_column_bit_i(scb), .beat_dq_i(dq),
    .lower_mask_inversion_lane_i(lm), .upper_mask_inversion_lane_i(um),
    .organisation_i(org), .mask_enable_i(mask_en), .check_hold_i(hold),
    .check_done_o(done), .crc_error_o(err), .crc_tree0_o(t0), .crc_tree1_o(t1),
    .burst_dropped_o(dropped));

  // Core clock, 100 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Serial reference CRC, bit 71 enters first
  function automatic logic [7:0] crc_of(input logic [71:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc_of

  // Tree input vector for one tree of one burst
  function automatic logic [71:0] tree_in(input logic [1:0] o, input logic s, input logic me,
                                          input int t, input logic [3:0][15:0] d,
                                          input logic [3:0] m);
    logic [71:0] v;
    v = '1;
    for (int n = 0; n < ((o == ORG_X4) ? 4 : 8); n++)
      for (int b = 0; b < 4; b++) v[8*n+4*s+b] = d[b][8*t+n];
    if (me && o != ORG_X4)
      for (int b = 0; b < 4; b++) v[64+4*s+b] = m[b];
    return v;
  endfunction : tree_in

  task automatic final_report();
    $display("Comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // Random burst; the expected result is noted before it is sent
  task automatic burst(input logic s, input logic bad, input int lead);
    logic [3:0][15:0] d;
    logic [3:0]       l, u;
    logic [7:0]       e0, e1;
    logic [15:0]      c;
    for (int b = 0; b < 4; b++) d[b] = 16'($urandom);
    l  = 4'($urandom);
    u  = 4'($urandom);
    e0 = crc_of(tree_in(org, s, mask_en, 0, d, l));
    e1 = crc_of(tree_in(org, s, mask_en, 1, d, u));
    c  = (org == ORG_X4) ? {8'hff, e0} : {e1, e0};
    if (bad) c = c ^ (16'h0001 << ((org == ORG_X16) ? $urandom_range(15) : $urandom_range(7)));
    notes.push_back('{org, e0, e1, bad});
    u_model.send(org, s, d, l, u, c, lead);
  endtask : burst

  task automatic do_reset(input logic [1:0] o, input logic me);
    @(posedge core_clk_i);
    #1;
    nrst_i  = 1'b0;
    org     = o;
    mask_en = me;
    fork
      u_model.idle(3);
      repeat (4) @(posedge core_clk_i);
    join
    `CHK("tree0 in reset", 8'h00, t0)
    #1 nrst_i = 1'b1;
    u_model.idle(3);
  endtask : do_reset

  // Bounded wait for every noted result to come back
  task automatic drain();
    for (int i = 0; i < 400 && notes.size() != 0; i++) @(posedge core_clk_i);
    `CHK("results outstanding", 0, notes.size())
  endtask : drain

  // Result watcher, sampled at the falling edge where outputs are settled
  always @(negedge core_clk_i) begin
    note_type nt;
    cycles++;
    if (dropped === 1'b1) drops++;
    if (done === 1'b1) begin
      checks++;
      if (notes.size() == 0) `CHK("unexpected check", 1'b0, 1'b1)
      else begin
        nt = notes.pop_front();
        `CHK("tree0", nt.t0, t0)
        if (nt.org == ORG_X16) `CHK("tree1", nt.t1, t1)
        `CHK("crc_error", nt.err, err)
      end
    end
    if (cycles > 60000) begin
      fails++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    nrst_i  = 1'b0;
    hold    = 1'b0;
    org     = ORG_X8;
    mask_en = 1'b0;
    void'($urandom(19977));
    // Every organisation, mask setting, half and CRC outcome
    for (int o = 0; o < 3; o++) begin
      for (int me = 0; me < 2; me++) begin
        do_reset(o[1:0], me[0]);
        for (int k = 0; k < 4; k++) burst(k[0], k[1], 2);
        drain();
        $display("Test mapping org %0d mask %0d done", o, me);
      end
    end
    // Back-to-back bursts with random half and outcome
    for (int k = 0; k < 6; k++) burst(1'($urandom), 1'($urandom), 0);
    drain();
    $display("Test back to back done");
    // Stall the checker until the buffer refuses, then drain
    do_reset(ORG_X8, 1'b1);
    c0    = checks;
    drops = 0;
    @(posedge core_clk_i);
    #1 hold = 1'b1;
    for (int k = 0; k < 20; k++) burst(1'($urandom), 1'b0, 0);
    u_model.idle(3);
    `CHK("checks while held", c0, checks)
    @(posedge core_clk_i);
    #1 hold = 1'b0;
    repeat (100) @(posedge core_clk_i);
    `CHK("some dropped", 1'b1, drops > 0)
    `CHK("dropped are newest", drops, notes.size())
    notes.delete();
    burst(1'b1, 1'b1, 3);
    drain();
    $display("Test fill and drain done");
    final_report();
  end
endmodule : write_crc_bc4_input_mapping_tb_top

`default_nettype wire
